// >>> nsddr_pkg.sv
// Operation
// - a command byte is latched at a clock rise with only command latch high
// - after a command or address cycle the host returns the bus to idle next edge
// - an address byte is latched at a clock rise with only address latch high
// - host drives unused address bits low and gives each command its address cycles; this block sends address bytes as given and leaves both to the caller
// - write data starts with strobe low, direction high, both latches high
// - device stores a byte on every host strobe edge, strobe centred on data
// - write data ends by latching both latches low; two bytes follow
// - read data starts with lines released, direction low, gap met, latches high
// - read data runs while latches are high; host ends it latching them low
// - after power-up wait 100 microseconds, or until ready/busy reads high
// - first command is reset; then poll ready/busy through the reset busy time
// - host checks the parameter page checksum before using its contents; this block only computes o_rd_crc, user logic compares it
// - on a bad checksum read redundant copies while a signature is found; user logic picks each copy, this block only reads as requested
// - direction high means host drives data and strobe, low means device drives
// - host waits the gap time after entering bus idle before changing mode
// - before select the clock runs and both latches are low, then select setup
package nsddr_pkg;
   localparam int SYS_PERIOD_NS         = 40;
   localparam int PWR_UP_WAIT_NS        = 100000;
   localparam int SELECT_SETUP_TIME_NS  = 20;
   localparam int CMD_ADDR_DATA_GAP_NS  = 25;
   localparam int WRITE_POSTAMBLE_NS    = 30;
   localparam int TURNAROUND_DRIVE_NS   = 100;
   localparam int STROBE_ACCESS_NS      = 20;
   localparam int OUTPUT_TO_IDLE_NS     = 100;
   localparam int RB_FALL_WAIT_NS       = 200;
   localparam logic [7:0]  CMD_RESET    = 8'hff;
   localparam logic [15:0] CRC_POLY     = 16'h8005;
   localparam logic [15:0] CRC_INIT     = 16'hffff;

   // least times round up, never below one cycle
   function automatic int ns_to_cyc_up(input int ns);
      int c;
      c = (ns + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc_up

   localparam int PWR_UP_WAIT_CYC = ns_to_cyc_up(PWR_UP_WAIT_NS);
   localparam int SELECT_SETUP_CYC = ns_to_cyc_up(SELECT_SETUP_TIME_NS);
   localparam int GAP_CYC = ns_to_cyc_up(CMD_ADDR_DATA_GAP_NS);
   localparam int WPST_CYC = ns_to_cyc_up(WRITE_POSTAMBLE_NS);
   localparam int TURN_CYC = ns_to_cyc_up(TURNAROUND_DRIVE_NS);
   localparam int RD_START_CYC = (TURN_CYC > GAP_CYC) ? TURN_CYC : GAP_CYC;
   localparam int RD_IDLE_CYC = ns_to_cyc_up(OUTPUT_TO_IDLE_NS + STROBE_ACCESS_NS);
   localparam int RB_FALL_CYC = ns_to_cyc_up(RB_FALL_WAIT_NS);

   typedef enum logic [1:0] {
      OP_CMD   = 2'b00,
      OP_ADDR  = 2'b01,
      OP_WRITE = 2'b10,
      OP_READ  = 2'b11
   } nsddr_kind_t;

   typedef struct packed {
      nsddr_kind_t kind;
      logic [7:0]  data;
      logic [15:0] count;
   } nsddr_op_t;

   typedef struct packed {
      logic       ce_n;
      logic       cle;
      logic       ale;
      logic       clk;
      logic       wr_rd;
      logic [7:0] dq;
      logic       dq_oe;
      logic       dqs;
      logic       dqs_oe;
   } nsddr_pins_t;
endpackage : nsddr_pkg

// >>> nsddr_host.sv
module nsddr_host #(
   parameter logic [7:0]  CLK_HALF     = 8'h04,
   parameter bit          USE_RB       = 1'b1,
   parameter logic [15:0] POR_BUSY_CYC = 16'h61a8,
   parameter logic [15:0] PWR_WAIT_CYC = 16'(nsddr_pkg::PWR_UP_WAIT_CYC)
) (
   // system
   input  wire logic               i_clk_sys,
   input  wire logic               i_reset_n,
   // operation request
   input  wire logic               i_op_valid,
   input  wire nsddr_pkg::nsddr_op_t i_op,
   output logic                    o_op_ready,
   // write stream
   input  wire logic [7:0]         i_wr_data,
   output logic                    o_wr_take,
   // read stream
   output logic                    o_rd_valid,
   output logic [7:0]              o_rd_data,
   output logic [15:0]             o_rd_crc,
   // status
   output logic                    o_init_done,
   output logic                    o_init_timeout,
   // flash pins
   output logic                    o_ce_n,
   output logic                    o_cle,
   output logic                    o_ale,
   output logic                    o_nand_clk,
   output logic                    o_wr_rd,
   output logic                    o_wp_n,
   input  wire logic [7:0]         i_dq,
   output logic [7:0]              o_dq,
   output logic                    o_dq_oe,
   input  wire logic               i_dqs,
   output logic                    o_dqs,
   output logic                    o_dqs_oe,
   input  wire logic               i_rb
);
   import nsddr_pkg::*;

   typedef enum logic [3:0] {
      S_PWR_WAIT  = 4'h0,
      S_SELECT    = 4'h1,
      S_CMD       = 4'h2,
      S_INIT_BUSY = 4'h3,
      S_GAP       = 4'h4,
      S_IDLE      = 4'h5,
      S_WR        = 4'h6,
      S_WR_POST   = 4'h7,
      S_RD_TURN   = 4'h8,
      S_RD        = 4'h9,
      S_RD_END    = 4'ha
   } nsddr_state_t;

   typedef struct packed {
      nsddr_state_t st;
      nsddr_pins_t  pins;
      logic [7:0]   div;
      logic [15:0]  timer;
      logic [15:0]  cnt;
      logic [15:0]  pairs;
      logic         skip;
      logic         pend;
      logic         rb_s1;
      logic         rb_s2;
      logic         dqs_s1;
      logic         dqs_s2;
      logic         dqs_s3;
      logic [7:0]   dq_s1;
      logic [7:0]   dq_s2;
      logic         edge_seen;
      logic         init_done;
      logic         init_timeout;
      logic         wr_take;
      logic         rd_valid;
      logic [7:0]   rd_data;
      logic [15:0]  crc;
   } nsddr_regs_t;

   // read tail covers output to idle plus the synchroniser and strobe latency
   localparam logic [15:0] RD_TAIL = 16'(RD_IDLE_CYC + 2 * int'(CLK_HALF) + 4);

   localparam nsddr_regs_t REG_RST = '{
      st:     S_PWR_WAIT,
      pins:   '{ce_n: 1'b1, wr_rd: 1'b1, default: '0},
      timer:  PWR_WAIT_CYC,
      crc:    CRC_INIT,
      default: '0
   };

   nsddr_regs_t state_reg;
   nsddr_regs_t state_next;
   logic        tick;
   logic        rise;
   logic        fall;
   logic        mid;
   logic [15:0] cnt_after;

   // checksum step over one byte, msb first
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc;
      for (int i = 7; i >= 0; i--) begin
         c = (c[15] ^ b[i]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
      end
      return c;
   endfunction : crc_step

   // link clock phase events; latch, direction and command pins change on falls so they sit still at rises
   assign tick = (state_reg.div == CLK_HALF - 8'h01);
   assign rise = tick && !state_reg.pins.clk;
   assign fall = tick && state_reg.pins.clk;
   assign mid  = (state_reg.div == (CLK_HALF >> 1) - 8'h01);
   assign cnt_after = state_reg.pend ? state_reg.cnt - 16'h0001 : state_reg.cnt;

   // requests are only taken on a fall tick from bus idle
   assign o_op_ready = (state_reg.st == S_IDLE) && fall;

   // next state of the whole controller
   always_comb begin
      state_next = state_reg;
      state_next.wr_take = 1'b0;
      state_next.rd_valid = 1'b0;
      // link clock divider; this end makes the clock, so no second domain
      state_next.div = tick ? 8'h00 : state_reg.div + 8'h01;
      if (tick) begin
         state_next.pins.clk = !state_reg.pins.clk;
      end
      // two-stage synchronisers for every pin driven by the flash
      state_next.rb_s1 = i_rb;
      state_next.rb_s2 = state_reg.rb_s1;
      state_next.dqs_s1 = i_dqs;
      state_next.dqs_s2 = state_reg.dqs_s1;
      state_next.dqs_s3 = state_reg.dqs_s2;
      state_next.dq_s1 = i_dq;
      state_next.dq_s2 = state_reg.dq_s1;
      // shared delay timer
      // every wait loads a cycle count from the package or a module parameter, so one down-counter serves them all
      if (state_reg.timer != 16'h0000) begin
         state_next.timer = state_reg.timer - 16'h0001;
      end
      // capture on strobe edges
      // data is taken a cycle after the edge so edge-aligned bytes have settled
      state_next.edge_seen = ((state_reg.st == S_RD) || (state_reg.st == S_RD_END))
                             && (state_reg.dqs_s2 != state_reg.dqs_s3);
      if (state_reg.edge_seen) begin
         state_next.rd_valid = 1'b1;
         state_next.rd_data = state_reg.dq_s2;
         state_next.crc = crc_step(state_reg.crc, state_reg.dq_s2);
      end
      unique case (state_reg.st)
         S_PWR_WAIT: begin
            if (USE_RB ? state_reg.rb_s2 : (state_reg.timer == 16'h0000)) begin
               // clock runs, latches low, then select
               state_next.pins.ce_n = 1'b0;
               state_next.timer = 16'(SELECT_SETUP_CYC);
               state_next.st = S_SELECT;
            end
         end
         S_SELECT: begin
            if (state_reg.timer == 16'h0000 && fall) begin
               state_next.pins.cle = 1'b1;
               state_next.pins.dq = CMD_RESET;
               state_next.pins.dq_oe = 1'b1;
               state_next.st = S_CMD;
            end
         end
         S_CMD: begin
            if (fall) begin
               state_next.pins.cle = 1'b0;
               state_next.pins.ale = 1'b0;
               state_next.skip = 1'b1;
               if (state_reg.init_done) begin
                  state_next.st = S_GAP;
               end else begin
                  state_next.timer = POR_BUSY_CYC;
                  state_next.st = S_INIT_BUSY;
               end
            end
         end
         S_INIT_BUSY: begin
            if (state_reg.timer == 16'h0000) begin
               state_next.init_done = 1'b1;
               state_next.init_timeout = USE_RB;
               state_next.st = S_GAP;
            end else if (USE_RB && state_reg.rb_s2 &&
                         state_reg.timer <= POR_BUSY_CYC - 16'(RB_FALL_CYC)) begin
               state_next.init_done = 1'b1;
               state_next.st = S_GAP;
            end
         end
         S_GAP: begin
            if (rise && state_reg.skip) begin
               state_next.skip = 1'b0;
               state_next.timer = 16'(GAP_CYC);
            end else if (!state_reg.skip && state_reg.timer == 16'h0000) begin
               state_next.st = S_IDLE;
            end
         end
         S_IDLE: begin
            if (i_op_valid && o_op_ready) begin
               state_next.pins.dq = i_op.data;
               state_next.cnt = (i_op.count[15:1] == 15'h0000) ? 16'h0002
                                : {i_op.count[15:1], 1'b0};
               state_next.pairs = (i_op.count[15:1] == 15'h0000) ? 16'h0001
                                  : {1'b0, i_op.count[15:1]};
               state_next.skip = 1'b1;
               state_next.pend = 1'b0;
               unique case (i_op.kind)
                  OP_CMD: begin
                     state_next.pins.cle = 1'b1;
                     state_next.pins.dq_oe = 1'b1;
                     state_next.st = S_CMD;
                  end
                  OP_ADDR: begin
                     // address byte as given
                     // the caller zeroes unused bits and issues each command's address count
                     // address latch high
                     state_next.pins.ale = 1'b1;
                     state_next.pins.dq_oe = 1'b1;
                     state_next.st = S_CMD;
                  end
                  OP_WRITE: begin
                     state_next.pins.cle = 1'b1;
                     state_next.pins.ale = 1'b1;
                     state_next.pins.dq_oe = 1'b1;
                     state_next.pins.dqs = 1'b0;
                     state_next.pins.dqs_oe = 1'b1;
                     state_next.st = S_WR;
                  end
                  OP_READ: begin
                     state_next.pins.dq_oe = 1'b0;
                     state_next.pins.dqs_oe = 1'b0;
                     state_next.pins.wr_rd = 1'b0;
                     state_next.timer = 16'(RD_START_CYC);
                     state_next.crc = CRC_INIT;
                     state_next.st = S_RD_TURN;
                  end
               endcase
            end
         end
         S_WR: begin
            // byte changes mid-way between strobe edges
            if (mid && !state_reg.skip && state_reg.cnt != 16'h0000 && !state_reg.pend) begin
               state_next.pins.dq = i_wr_data;
               state_next.wr_take = 1'b1;
               state_next.pend = 1'b1;
            end
            if (tick && state_reg.pend) begin
               state_next.pins.dqs = !state_reg.pins.dqs;
               state_next.pend = 1'b0;
               state_next.cnt = cnt_after;
            end
            if (fall) begin
               state_next.skip = 1'b0;
               if (cnt_after == 16'h0002) begin
                  state_next.pins.cle = 1'b0;
                  state_next.pins.ale = 1'b0;
               end
            end
            if (tick && state_reg.pend && state_reg.cnt == 16'h0001) begin
               state_next.timer = 16'(WPST_CYC);
               state_next.st = S_WR_POST;
            end
         end
         S_WR_POST: begin
            if (state_reg.timer == 16'h0000) begin
               state_next.pins.dq_oe = 1'b0;
               state_next.pins.dqs_oe = 1'b0;
               state_next.skip = 1'b1;
               state_next.st = S_GAP;
            end
         end
         S_RD_TURN: begin
            if (state_reg.timer == 16'h0000 && fall) begin
               state_next.pins.cle = 1'b1;
               state_next.pins.ale = 1'b1;
               state_next.st = S_RD;
            end
         end
         S_RD: begin
            // one latched high cycle per byte pair
            if (fall) begin
               state_next.pairs = state_reg.pairs - 16'h0001;
               if (state_reg.pairs == 16'h0001) begin
                  state_next.pins.cle = 1'b0;
                  state_next.pins.ale = 1'b0;
                  state_next.timer = RD_TAIL;
                  state_next.st = S_RD_END;
               end
            end
         end
         S_RD_END: begin
            // wait last pair and output to idle
            // direction high releases the device drivers
            if (state_reg.timer == 16'h0000 && fall) begin
               state_next.pins.wr_rd = 1'b1;
               state_next.skip = 1'b1;
               state_next.st = S_GAP;
            end
         end
         default: begin
            state_next = REG_RST;
         end
      endcase
   end

   // single state register; reset loads constants only
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= REG_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // pin and status outputs straight from the state register, write protect tied high
   assign o_ce_n         = state_reg.pins.ce_n;
   assign o_cle          = state_reg.pins.cle;
   assign o_ale          = state_reg.pins.ale;
   assign o_nand_clk     = state_reg.pins.clk;
   assign o_wr_rd        = state_reg.pins.wr_rd;
   assign o_dq           = state_reg.pins.dq;
   assign o_dq_oe        = state_reg.pins.dq_oe;
   assign o_dqs          = state_reg.pins.dqs;
   assign o_dqs_oe       = state_reg.pins.dqs_oe;
   assign o_wp_n         = 1'b1; // write protect is outside this block
   assign o_wr_take      = state_reg.wr_take;
   assign o_rd_valid     = state_reg.rd_valid;
   assign o_rd_data      = state_reg.rd_data;
   // checksum for copies
   // user logic compares this per copy and decides whether to read the next one
   assign o_rd_crc       = state_reg.crc;
   assign o_init_done    = state_reg.init_done;
   assign o_init_timeout = state_reg.init_timeout;
endmodule : nsddr_host

// >>> nsddr_host_monitor.sv
module nsddr_host_monitor #(
   parameter logic [7:0] CLK_HALF = 8'h04
) (
   // system
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // host status
   input wire logic o_op_ready,
   input wire logic o_rd_valid,
   input wire logic o_init_done,
   // flash pins
   input wire logic o_ce_n,
   input wire logic o_cle,
   input wire logic o_ale,
   input wire logic o_nand_clk,
   input wire logic o_wr_rd,
   input wire logic o_dq_oe,
   input wire logic o_dqs,
   input wire logic o_dqs_oe
);
   logic [7:0] hi_cnt;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);

   // high-phase length of the link clock, checked at each fall
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) hi_cnt <= 8'h00;
      else hi_cnt <= o_nand_clk ? hi_cnt + 8'h01 : 8'h00;
   end

   cmd_dir_a: assert property ((o_cle ^ o_ale) |-> !o_ce_n && o_wr_rd)
      else $error("cmd or addr cycle off a selected host bus");
   latch_edge_a: assert property (($changed(o_cle) || $changed(o_ale)) |-> !o_nand_clk)
      else $error("latch strobe moved while link clock high");
   cmd_period_a: assert property ($rose(o_cle) && !o_ale |=> o_cle [*7] ##1 !o_cle)
      else $error("cmd latch not one link period");
   write_entry_a: assert property ($rose(o_cle) && o_ale && o_wr_rd |-> o_dqs_oe && !o_dqs)
      else $error("write entry without low driven strobe");
   host_dir_a: assert property ((o_dq_oe || o_dqs_oe) |-> o_wr_rd)
      else $error("host drives lanes with direction low");
   read_turn_a: assert property ($rose(o_cle) && !o_wr_rd |-> $past(o_wr_rd, 3) == 1'b0)
      else $error("read latches before turnaround");
   post_amble_a: assert property ($fell(o_dqs_oe) && o_wr_rd |-> $past(o_dqs) == 1'b0)
      else $error("strobe released while high");
   ready_idle_a: assert property (o_op_ready |-> o_init_done && !o_cle && !o_ale && o_wr_rd)
      else $error("ready outside idle");
   select_clean_a: assert property ($fell(o_ce_n) |-> !o_cle && !o_ale)
      else $error("select with a latch high");
   link_half_a: assert property ($fell(o_nand_clk) |-> hi_cnt == CLK_HALF)
      else $error("link clock high phase length wrong");

   cover property ($rose(o_cle) && !o_ale);
   cover property ($rose(o_cle) && o_ale && o_wr_rd);
   cover property ($rose(o_cle) && o_ale && !o_wr_rd);
   cover property (o_rd_valid);
endmodule : nsddr_host_monitor

bind nsddr_host nsddr_host_monitor #(.CLK_HALF(CLK_HALF)) mon_u (
   .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .o_op_ready(o_op_ready),
   .o_rd_valid(o_rd_valid), .o_init_done(o_init_done), .o_ce_n(o_ce_n), .o_cle(o_cle),
   .o_ale(o_ale), .o_nand_clk(o_nand_clk), .o_wr_rd(o_wr_rd), .o_dq_oe(o_dq_oe),
   .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe));

// >>> nsddr_dev_model.sv
module nsddr_dev_model #(
   parameter int PWR_NS    = 2000,
   parameter int BUSY_NS   = 30000,
   parameter int ACCESS_NS = 20
) (
   // host-driven pins
   input  wire logic       i_ce_n,
   input  wire logic       i_cle,
   input  wire logic       i_ale,
   input  wire logic       i_clk,
   input  wire logic       i_wr_rd,
   input  wire logic [7:0] i_dq,
   input  wire logic       i_dqs,
   input  wire logic       i_dqs_oe,
   // die-driven pins
   output logic [7:0]      o_dq,
   output logic            o_dqs,
   output logic            o_drive,
   output logic            o_rb
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] last_cmd = 8'h00, addr_q[$], wr_q[$];
   logic in_write = 1'b0;
   int rd_idx = 0, first_ok = 1, seen = 0;

   // busy line low until supplies settle, default interface
   initial begin
      {o_dq, o_dqs, o_drive, o_rb} = '0;
      #(PWR_NS) o_rb = 1'b1;
   end
   // reset or program confirm keeps the die busy for a while
   always @(negedge o_rb) if (seen != 0) #(BUSY_NS) o_rb = 1'b1;

   // capture at link rise; busy die takes status only
   always @(posedge i_clk) begin
      if (!i_ce_n && i_wr_rd && i_cle && !i_ale) begin
         if (seen == 0 && (i_dq !== 8'hff || !o_rb)) first_ok = 0;
         seen = 1;
         if (o_rb || i_dq == 8'h70 || i_dq == 8'h78) begin
            last_cmd = i_dq;
            rd_idx = 0;
         end
         if (o_rb && (i_dq == 8'hff || i_dq == 8'h10)) o_rb = 1'b0;
      end
      if (!i_ce_n && i_wr_rd && i_ale && !i_cle && (o_rb || last_cmd == 8'h78))
         addr_q.push_back(i_dq);
      // write entry only for a ready die
      if (!i_ce_n && i_wr_rd && i_cle && i_ale) in_write = o_rb;
      // direction low: die drives, strobe low; released lines wander
      if (!i_ce_n && i_wr_rd && o_drive) o_dqs <= ~o_dqs;
      if (!i_ce_n && !i_wr_rd && !o_drive) o_dqs <= 1'b0;
      if (!i_ce_n) o_drive <= !i_wr_rd;
      if (!o_drive) o_dq <= ~o_dq;
   end

   // a byte on every host strobe edge while in write data
   always @(i_dqs) if (in_write && i_dqs_oe && !i_ce_n) wr_q.push_back(i_dq);
   // write data ends once the host lets go of the strobe
   always @(negedge i_dqs_oe) in_write = 1'b0;

   function automatic logic [7:0] next_byte();
      rd_idx++;
      if (last_cmd inside {8'h70, 8'h78}) return {1'b1, o_rb, o_rb, 5'h00};
      return 8'((rd_idx - 1) * 29 + 60);
   endfunction : next_byte

   // two bytes per latched rise, strobe trails the clock
   always @(posedge i_clk) begin
      if (!i_ce_n && !i_wr_rd && i_cle && i_ale && (o_rb || last_cmd inside {8'h70, 8'h78})) begin
         #(ACCESS_NS) o_dqs = 1'b1;
         o_dq = next_byte();
         @(negedge i_clk);
         #(ACCESS_NS) o_dqs = 1'b0;
         o_dq = next_byte();
      end
   end
endmodule : nsddr_dev_model

// >>> test_nsddr_host.sv
module test_nsddr_host;
   timeunit 1ns;
   timeprecision 1ns;
   import nsddr_pkg::*;
   logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_op_valid = 1'b0;
   nsddr_op_t i_op = '0;
   logic [7:0] i_wr_data = 8'h00, o_rd_data, o_dq, dev_dq, c, wr_buf[$], rd_q[$];
   logic [15:0] o_rd_crc;
   logic o_op_ready, o_wr_take, o_rd_valid, o_init_done, o_init_timeout, o_ce_n, o_cle;
   logic o_ale, o_nand_clk, o_wr_rd, o_wp_n, o_dq_oe, o_dqs, o_dqs_oe, dev_dqs, dev_drv, i_rb;
   int err_count = 0, total_checks = 0, wr_idx = 0, na, n;
   // host lanes win while driven, otherwise the die's lines
   wire [7:0] i_dq = o_dq_oe ? o_dq : dev_dq;
   wire i_dqs = o_dqs_oe ? o_dqs : dev_dqs;

   nsddr_host #(.PWR_WAIT_CYC(16'h0014), .POR_BUSY_CYC(16'h0800)) dut_u (.*);
   nsddr_dev_model dev_u (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_clk(o_nand_clk),
      .i_wr_rd(o_wr_rd), .i_dq(i_dq), .i_dqs(i_dqs), .i_dqs_oe(o_dqs_oe), .o_dq(dev_dq),
      .o_dqs(dev_dqs), .o_drive(dev_drv), .o_rb(i_rb));

   always #20 i_clk_sys = ~i_clk_sys;
   // next write byte goes up once the host has taken the current one
   always @(negedge i_clk_sys) if (o_wr_take === 1'b1) i_wr_data = wr_buf[++wr_idx];
   // read bytes collected as the host hands them over
   always @(negedge i_clk_sys) if (o_rd_valid === 1'b1) rd_q.push_back(o_rd_data);

   task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_byte
   task automatic chk_num(string nm, int e, int g);
      total_checks++;
      if (g != e) begin
         err_count++;
         $display("Error %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_num
   task automatic chk_crc(string nm, logic [15:0] e, logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_crc
   // reference checksum step over one byte, msb first
   function automatic logic [15:0] crc_ref(logic [15:0] c, logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         c = (c[15] ^ b[i]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
      end
      return c;
   endfunction : crc_ref
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic wait_ready();
      for (int k = 0; k < 3000; k++) begin
         @(negedge i_clk_sys);
         if (o_op_ready === 1'b1) return;
      end
      chk_num("op_ready_wait", 1, 0);
      wrap_up();
   endtask : wait_ready
   // request held from a ready cycle through its taking edge, then completion
   task automatic send_op(nsddr_kind_t k, logic [7:0] d, logic [15:0] cnt);
      wait_ready();
      i_op = '{k, d, cnt};
      i_op_valid = 1'b1;
      @(negedge i_clk_sys);
      i_op_valid = 1'b0;
      wait_ready();
   endtask : send_op
   task automatic do_write(int cnt, int exp_n);
      wr_buf.delete();
      repeat (cnt + 2) wr_buf.push_back(8'($urandom));
      wr_idx = 0;
      i_wr_data = wr_buf[0];
      na = dev_u.wr_q.size();
      send_op(OP_WRITE, 8'h00, 16'(cnt));
      chk_num("wr_count", na + exp_n, dev_u.wr_q.size());
      for (int i = 0; i < exp_n; i++) chk_byte("wr_byte", wr_buf[i], dev_u.wr_q[na + i]);
   endtask : do_write
   // stat zero means array data, otherwise every byte is that status value
   task automatic do_read(int cnt, int exp_n, logic [7:0] stat);
      logic [15:0] e;
      rd_q.delete();
      send_op(OP_READ, 8'h00, 16'(cnt));
      chk_num("rd_count", exp_n, rd_q.size());
      foreach (rd_q[i]) chk_byte("rd_byte", stat != 8'h00 ? stat : 8'(i * 29 + 60), rd_q[i]);
      // checksum restarts at each read request and covers every byte handed over
      e = CRC_INIT;
      for (int i = 0; i < exp_n; i++) e = crc_ref(e, stat != 8'h00 ? stat : 8'(i * 29 + 60));
      chk_crc("rd_crc", e, o_rd_crc);
   endtask : do_read

   initial begin
      #4000000;
      chk_num("run_time", 0, 1);
      wrap_up();
   end

   initial begin
      void'($urandom(32'ha197));
      repeat (20) @(negedge i_clk_sys);
      i_reset_n = 1'b1;
      for (n = 0; n < 5000 && o_init_done !== 1'b1; n++) @(negedge i_clk_sys);
      chk_byte("init_done", 8'h01, {7'h00, o_init_done});
      chk_byte("init_timeout", 8'h00, {7'h00, o_init_timeout});
      chk_byte("wp_n", 8'h01, {7'h00, o_wp_n});
      chk_num("first_cmd", 1, dev_u.first_ok);
      if (n == 5000) wrap_up();
      // command and address cycles, fixed codes first, then random ones
      for (int i = 0; i < 8; i++) begin
         c = (i < 4) ? 8'(8'hee >> (2 * i)) : 8'h20 | (8'($urandom) & 8'h1f);
         send_op(OP_CMD, c, 16'h0000);
         chk_byte("last_cmd", c, dev_u.last_cmd);
         c = 8'($urandom);
         na = dev_u.addr_q.size();
         send_op(OP_ADDR, c, 16'h0000);
         chk_byte("addr", c, dev_u.addr_q[na]);
      end
      do_write(0, 2);
      do_write(5, 4);
      repeat (3) begin
         n = 2 * $urandom_range(1, 12);
         do_write(n, n);
      end
      for (int i = 0; i < 4; i++) begin
         n = (i == 0) ? 1 : 2 * $urandom_range(1, 10);
         send_op(OP_CMD, 8'h00, 16'h0000);
         do_read(n, (n < 2) ? 2 : n, 8'h00);
      end
      // program confirm leaves the die busy; only status traffic gets through
      send_op(OP_CMD, 8'h10, 16'h0000);
      send_op(OP_CMD, 8'h00, 16'h0000);
      chk_byte("busy_cmd", 8'h10, dev_u.last_cmd);
      na = dev_u.addr_q.size();
      send_op(OP_ADDR, 8'h5a, 16'h0000);
      chk_num("busy_addr", na, dev_u.addr_q.size());
      do_read(2, 0, 8'h80);
      send_op(OP_CMD, 8'h70, 16'h0000);
      do_read(4, 4, 8'h80);
      send_op(OP_CMD, 8'h78, 16'h0000);
      send_op(OP_ADDR, 8'ha5, 16'h0000);
      chk_byte("status_addr", 8'ha5, dev_u.addr_q[na]);
      do_write(4, 0);
      for (n = 0; n < 2000 && i_rb !== 1'b1; n++) @(negedge i_clk_sys);
      chk_num("rb_ready", 1, int'(i_rb === 1'b1));
      send_op(OP_CMD, 8'h70, 16'h0000);
      do_read(2, 2, 8'he0);
      wrap_up();
   end
endmodule : test_nsddr_host
